// >>> src/bcm_mailbox.v
// simulation-side engine of one bypass channel mailbox in shared memory
// assumes the control unit reaches the shared window over the plain ecu_* port and keeps its own protocol
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "bcm_regs.vh"

module bcm_mailbox
#(
    parameter IN_SIZE  = `BCM_IN_SIZE,        // input_buffer_size
    parameter OUT_SIZE = `BCM_OUT_SIZE,       // output_buffer_size
    parameter [2:0] RASTER = `BCM_RASTER_ANGLE // channel identifier written by the control unit
)
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [8:0]  ecu_addr,
    input  wire [7:0]  ecu_wdata,
    input  wire        ecu_wr,
    input  wire        ecu_rd,
    output wire [7:0]  ecu_rdata,
    input  wire        setup_start,
    input  wire        setup_format,
    input  wire        setup_msb_first,
    input  wire [7:0]  setup_cnt8,
    input  wire [7:0]  setup_cnt4,
    input  wire [7:0]  setup_cnt2,
    input  wire [7:0]  setup_cnt1,
    input  wire        setup_valid,
    input  wire        setup_is_ofs,
    input  wire        setup_last,
    input  wire [31:0] setup_data,
    output reg         setup_ready,
    output reg         chan_active,
    output reg         trig_seen,
    output reg  [7:0]  trig_id,
    output reg         trig_match,
    output reg         in_valid,
    output reg         in_last,
    output reg  [7:0]  in_data,
    input  wire        res_valid,
    input  wire [7:0]  res_data,
    output reg         res_ready,
    output reg  [7:0]  out_count
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [3:0] S_IDLE  = 4'd0;    // waiting for experiment start
    localparam [3:0] S_LIST  = 4'd1;    // taking pointers and offsets
    localparam [3:0] S_PBYTE = 4'd2;    // spilling one pointer into bytes
    localparam [3:0] S_HDR   = 4'd3;    // length or counts
    localparam [3:0] S_ACT   = 4'd4;    // active flag
    localparam [3:0] S_RUN   = 4'd5;    // waiting for a trigger
    localparam [3:0] S_TID   = 4'd6;    // issue identifier read
    localparam [3:0] S_TW1   = 4'd7;    // identifier read in flight
    localparam [3:0] S_TW2   = 4'd8;    // identifier captured
    localparam [3:0] S_RDIN  = 4'd9;    // reading input buffer
    localparam [3:0] S_RES   = 4'd10;   // taking results
    localparam [3:0] S_PUB   = 4'd11;   // publishing counter

    localparam [8:0] IN_SIZE_W  = IN_SIZE[8:0];
    localparam [8:0] OUT_SIZE_W = OUT_SIZE[8:0];
    localparam integer PTR_MAX  = `BCM_PTR_MAX;     // list bytes, cut to the window width below
    localparam [8:0] PTR_MAX_W  = PTR_MAX[8:0];

    // ****************************************************************
    // registers
    // ****************************************************************
    reg  [3:0]  state_r;                // engine state
    reg         fmt_r;                  // latched table format
    reg         msbf_r;                 // latched byte order
    reg  [31:0] cnts_r;                 // counts 8,4,2,1 from high to low byte
    reg  [7:0]  ptr_n_r;                // pointers placed so far
    reg  [8:0]  wptr_r;                 // next list byte address
    reg  [7:0]  ofs_idx_r;              // next offset parameter
    reg  [31:0] word_r;                 // pointer being spilled
    reg  [2:0]  nb_r;                   // bytes left in word_r
    reg         last_r;                 // final pointer seen
    reg  [1:0]  hdr_r;                  // header byte index
    reg         trig_pend_r;            // trigger waiting for service
    reg  [7:0]  cnt_r;                  // internal output counter
    reg  [8:0]  idx_r;                  // buffer byte index
    reg  [8:0]  len_r;                  // input bytes to read
    reg         rv1_r;                  // input read at memory
    reg         rl1_r;                  // ... and it is the last
    reg  [8:0]  b_addr_r;               // engine port address
    reg  [7:0]  b_wdata_r;              // engine port write data
    reg         b_we_r;                 // engine port write
    reg         b_re_r;                 // engine port read
    wire [7:0]  b_rdata;                // engine port read data

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // trigger detection on the control unit port, value ignored
    wire trig_hit = ecu_wr && (ecu_addr == `BCM_TRG_LOC);

    // count of input bytes in signal-wise form, clamped to buffer size
    wire [11:0] sw_len = {1'b0, cnts_r[31:24], 3'b000} + {2'b00, cnts_r[23:16], 2'b00}
                       + {3'b000, cnts_r[15:8], 1'b0} + {4'h0, cnts_r[7:0]};
    wire [11:0] raw_len = (fmt_r == `BCM_FMT_SIGNALWISE) ? sw_len : {4'h0, ptr_n_r};
    wire [8:0]  in_len  = (raw_len > {3'b000, IN_SIZE_W}) ? IN_SIZE_W : raw_len[8:0];

    // byte taken from the pointer word in the configured order
    function [7:0] pick_byte;
        input [31:0] w;
        input [2:0]  left;
        input        msb_first;
        input [2:0]  width;
        reg   [2:0]  pos;
        begin
            pos = msb_first ? (left - 3'd1) : (width - left);
            pick_byte = w[{pos[1:0], 3'b000} +: 8];
        end
    endfunction

    wire [2:0] ptr_w = (fmt_r == `BCM_FMT_SIGNALWISE) ? `BCM_SW_PTR_BYTES : `BCM_BW_PTR_BYTES;

    // odd count selects the first buffer, even the second; only bit 0 matters after a wrap
    wire [8:0] out_base = cnt_r[0] ? `BCM_OUT1_BASE : (`BCM_OUT1_BASE + OUT_SIZE_W);

    // ****************************************************************
    // shared memory
    // ****************************************************************
    bcm_shared_mem
    #(
        .AW (`BCM_AW),
        .DW (8)
    )
    u_mem
    (
        .clk     (clk),
        .a_addr  (ecu_addr),
        .a_wdata (ecu_wdata),
        .a_we    (ecu_wr),
        .a_re    (ecu_rd),
        .a_rdata (ecu_rdata),
        .b_addr  (b_addr_r),
        .b_wdata (b_wdata_r),
        .b_we    (b_we_r),
        .b_re    (b_re_r),
        .b_rdata (b_rdata)
    );

    // ****************************************************************
    // trigger latch
    // ****************************************************************
    // a trigger arriving while the previous one is being taken is kept: set wins
    always @(posedge clk)
    begin
        if (sys_rst)
            trig_pend_r <= 1'b0;
        else if (trig_hit)
            trig_pend_r <= 1'b1;
        else if (state_r == S_RUN && trig_pend_r)
            trig_pend_r <= 1'b0;
    end

    // ****************************************************************
    // input stream pipeline
    // ****************************************************************
    // two stages: memory read, then output register
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            rv1_r    <= 1'b0;
            rl1_r    <= 1'b0;
            in_valid <= 1'b0;
            in_last  <= 1'b0;
            in_data  <= 8'h00;
        end
        else
        begin
            rv1_r    <= b_re_r && (state_r == S_RDIN || state_r == S_RES) && !b_we_r;
            rl1_r    <= b_re_r && (b_addr_r == `BCM_IN_BASE + len_r - 9'd1);
            in_valid <= rv1_r;
            in_last  <= rv1_r && rl1_r;
            in_data  <= rv1_r ? b_rdata : 8'h00;
        end
    end

    // ****************************************************************
    // engine
    // ****************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r     <= S_IDLE;
            fmt_r       <= `BCM_FMT_BYTEWISE;
            msbf_r      <= 1'b0;
            cnts_r      <= 32'h0000_0000;
            ptr_n_r     <= 8'h00;
            wptr_r      <= 9'h000;
            ofs_idx_r   <= 8'h00;
            word_r      <= 32'h0000_0000;
            nb_r        <= 3'd0;
            last_r      <= 1'b0;
            hdr_r       <= 2'd0;
            cnt_r       <= 8'h00;
            idx_r       <= 9'h000;
            len_r       <= 9'h000;
            b_addr_r    <= 9'h000;
            b_wdata_r   <= 8'h00;
            b_we_r      <= 1'b0;
            b_re_r      <= 1'b0;
            setup_ready <= 1'b0;
            res_ready   <= 1'b0;
            chan_active <= 1'b0;
            trig_seen   <= 1'b0;
            trig_id     <= 8'h00;
            trig_match  <= 1'b0;
            out_count   <= 8'h00;
        end
        else
        begin
            // port strobes are single cycle unless a state renews them
            b_we_r    <= 1'b0;
            b_re_r    <= 1'b0;
            trig_seen <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    // start is honoured only before activation: the list is filled once
                    if (setup_start)
                    begin
                        fmt_r       <= setup_format;
                        msbf_r      <= setup_msb_first;
                        cnts_r      <= {setup_cnt8, setup_cnt4, setup_cnt2, setup_cnt1};
                        wptr_r      <= (setup_format == `BCM_FMT_SIGNALWISE) ?
                                       `BCM_SW_FIRST_PTR : `BCM_BW_FIRST_PTR;
                        ptr_n_r     <= 8'h00;
                        ofs_idx_r   <= 8'h00;
                        setup_ready <= 1'b1;
                        state_r     <= S_LIST;
                    end
                end
                S_LIST:
                begin
                    if (setup_valid && setup_ready)
                    begin
                        if (setup_is_ofs)
                        begin
                            // offset parameter lands in the control unit's area
                            b_addr_r  <= `BCM_OFS_BASE + {1'b0, ofs_idx_r};
                            b_wdata_r <= setup_data[7:0];
                            b_we_r    <= 1'b1;
                            ofs_idx_r <= ofs_idx_r + 8'd1;
                            if (setup_last)
                            begin
                                setup_ready <= 1'b0;
                                state_r     <= S_HDR;
                                hdr_r       <= 2'd0;
                            end
                        end
                        else if (wptr_r + {6'd0, ptr_w} <= PTR_MAX_W)
                        begin
                            // one pointer per byte (byte-wise) or per signal address
                            word_r      <= setup_data;
                            nb_r        <= ptr_w;
                            last_r      <= setup_last;
                            ptr_n_r     <= ptr_n_r + 8'd1;
                            setup_ready <= 1'b0;
                            state_r     <= S_PBYTE;
                        end
                        else if (setup_last)
                        begin
                            // a list overflow is dropped rather than spilling into the input buffer
                            setup_ready <= 1'b0;
                            state_r     <= S_HDR;
                            hdr_r       <= 2'd0;
                        end
                    end
                end
                S_PBYTE:
                begin
                    b_addr_r  <= wptr_r;
                    b_wdata_r <= pick_byte(word_r, nb_r, msbf_r, ptr_w);
                    b_we_r    <= 1'b1;
                    wptr_r    <= wptr_r + 9'd1;
                    nb_r      <= nb_r - 3'd1;
                    if (nb_r == 3'd1)
                    begin
                        if (last_r)
                        begin
                            state_r <= S_HDR;
                            hdr_r   <= 2'd0;
                        end
                        else
                        begin
                            setup_ready <= 1'b1;
                            state_r     <= S_LIST;
                        end
                    end
                end
                S_HDR:
                begin
                    b_we_r <= 1'b1;
                    if (fmt_r == `BCM_FMT_BYTEWISE)
                    begin
                        // length written only after every pointer is in place
                        b_addr_r  <= `BCM_BW_LEN_BYTE;
                        b_wdata_r <= ptr_n_r;
                        state_r   <= S_ACT;
                    end
                    else
                    begin
                        b_addr_r  <= `BCM_SW_CNT_BYTE + {7'd0, hdr_r};
                        b_wdata_r <= cnts_r[{~hdr_r, 3'b000} +: 8];
                        hdr_r     <= hdr_r + 2'd1;
                        if (hdr_r == 2'd3)
                            state_r <= S_ACT;
                    end
                end
                S_ACT:
                begin
                    // flag is the last list write, so the control unit never sees a half list
                    b_addr_r    <= (fmt_r == `BCM_FMT_SIGNALWISE) ?
                                   `BCM_SW_ACT_BYTE : `BCM_BW_ACT_BYTE;
                    b_wdata_r   <= `BCM_ACT_VALUE;
                    b_we_r      <= 1'b1;
                    chan_active <= 1'b1;
                    state_r     <= S_RUN;
                end
                S_RUN:
                begin
                    if (trig_pend_r)
                    begin
                        cnt_r     <= cnt_r + 8'd1;
                        trig_seen <= 1'b1;
                        state_r   <= S_TID;
                    end
                end
                S_TID:
                begin
                    b_addr_r <= `BCM_TRGID_LOC;
                    b_re_r   <= 1'b1;
                    state_r  <= S_TW1;
                end
                S_TW1:
                begin
                    state_r <= S_TW2;
                end
                S_TW2:
                begin
                    // identifier picked up, then the input buffer is streamed out
                    trig_id    <= b_rdata;
                    trig_match <= (b_rdata == {5'd0, RASTER});
                    len_r      <= in_len;
                    idx_r      <= 9'h000;
                    if (in_len == 9'h000)
                    begin
                        res_ready <= 1'b1;
                        state_r   <= S_RES;
                    end
                    else
                        state_r <= S_RDIN;
                end
                S_RDIN:
                begin
                    b_addr_r <= `BCM_IN_BASE + idx_r;
                    b_re_r   <= 1'b1;
                    idx_r    <= idx_r + 9'd1;
                    if (idx_r == len_r - 9'd1)
                    begin
                        idx_r     <= 9'h000;
                        res_ready <= 1'b1;
                        state_r   <= S_RES;
                    end
                end
                S_RES:
                begin
                    if (res_valid && res_ready)
                    begin
                        // the other buffer keeps the previous copy intact meanwhile
                        b_addr_r  <= out_base + idx_r;
                        b_wdata_r <= res_data;
                        b_we_r    <= 1'b1;
                        idx_r     <= idx_r + 9'd1;
                        if (idx_r == OUT_SIZE_W - 9'd1)
                        begin
                            res_ready <= 1'b0;
                            state_r   <= S_PUB;
                        end
                    end
                end
                S_PUB:
                begin
                    // counter published only after the whole buffer is written
                    b_addr_r  <= `BCM_CNT_LOC;
                    b_wdata_r <= cnt_r;
                    b_we_r    <= 1'b1;
                    out_count <= cnt_r;
                    state_r   <= S_RUN;
                end
                default:
                begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

endmodule // bcm_mailbox

// >>> shared/bcm_regs.vh
// constants for the bypass channel mailbox: shared-memory layout, descriptor codes and field positions
// assumes a 512-byte shared window seen by the control unit and by the simulation-side engine
`ifndef BCM_REGS_VH
`define BCM_REGS_VH

// ****************************************************************
// shared memory layout (byte addresses)
// ****************************************************************
`define BCM_AW               9          // address width of the shared window
`define BCM_PTR_BASE         9'h000     // pointer list start
`define BCM_IN_BASE          9'h080     // input buffer start
`define BCM_TRGID_LOC        9'h0F0     // trigger identifier location
`define BCM_TRG_LOC          9'h0F1     // trigger location
`define BCM_OFS_BASE         9'h100     // output offset parameters, 55 bytes at most before the counter
`define BCM_CNT_LOC          9'h137     // published output counter
`define BCM_OUT1_BASE        9'h138     // first output buffer; the second follows and ends at 9'h1FF
`define BCM_IN_SIZE          100        // input buffer size in bytes
`define BCM_OUT_SIZE         100        // output buffer size in bytes
`define BCM_PTR_MAX          100        // pointer list size in bytes

// ****************************************************************
// pointer list fields
// ****************************************************************
`define BCM_BW_LEN_BYTE      9'h000     // byte-wise: list length byte
`define BCM_BW_ACT_BYTE      9'h001     // byte-wise: active-flag byte
`define BCM_BW_FIRST_PTR     9'h002     // byte-wise: first pointer
`define BCM_SW_ACT_BYTE      9'h000     // signal-wise: active-flag byte
`define BCM_SW_CNT_BYTE      9'h004     // signal-wise: count of 8-byte signals, then 4, 2, 1
`define BCM_SW_FIRST_PTR     9'h008     // signal-wise: first signal address
`define BCM_ACT_VALUE        8'h01      // active flag set in bit 0
`define BCM_BW_PTR_BYTES     3'd2       // byte-wise pointer width
`define BCM_SW_PTR_BYTES     3'd4       // signal-wise address width

// ****************************************************************
// descriptor raster codes and table format codes
// ****************************************************************
`define BCM_RASTER_ANGLE     3'd4       // angle-synchronous bypass channel
`define BCM_RASTER_TIME      3'd5       // time-synchronous bypass channel
`define BCM_FMT_BYTEWISE     1'b0       // bytewise_table_format
`define BCM_FMT_SIGNALWISE   1'b1       // signalwise_table_format and _ext

`endif

// >>> src/bcm_shared_mem.v
// dual-port shared emulation memory for the bypass channel mailbox
// assumes both ports in the clk domain; the two ports own disjoint regions by convention
`timescale 1ns/100ps

module bcm_shared_mem
#(
    parameter AW = 9,                   // address width
    parameter DW = 8                    // data width
)
(
    input  wire          clk,
    input  wire [AW-1:0] a_addr,
    input  wire [DW-1:0] a_wdata,
    input  wire          a_we,
    input  wire          a_re,
    output reg  [DW-1:0] a_rdata,
    input  wire [AW-1:0] b_addr,
    input  wire [DW-1:0] b_wdata,
    input  wire          b_we,
    input  wire          b_re,
    output reg  [DW-1:0] b_rdata
);

    reg [DW-1:0] mem_r [0:(1<<AW)-1];   // storage, no reset: contents undefined until written

    // ****************************************************************
    // port a (control unit) and port b (engine)
    // ****************************************************************
    // one process owns the array; read data registered, one cycle after the strobe
    // same-address writes are not arbitrated (b lands last); regions keep them apart
    always @(posedge clk)
    begin
        if (a_we)
            mem_r[a_addr] <= a_wdata;
        if (b_we)
            mem_r[b_addr] <= b_wdata;
        if (a_re)
            a_rdata <= mem_r[a_addr];
        if (b_re)
            b_rdata <= mem_r[b_addr];
    end

endmodule // bcm_shared_mem

// >>> testbench/bcm_mailbox_assertions.sv
// port checker for the mailbox: trigger service, input stream, setup and counter publish
// assumes one clock domain with synchronous reset; attached by bind below
`timescale 1ns/100ps
module bcm_mailbox_checker (
    input wire       clk, input wire sys_rst, input wire setup_valid, input wire setup_is_ofs,
    input wire       setup_ready, input wire chan_active, input wire trig_seen, input wire [7:0] trig_id,
    input wire       trig_match, input wire in_valid, input wire in_last, input wire res_ready,
    input wire [7:0] out_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // pulses and ordering of the trigger service
    trig_pulse_a: assert property (trig_seen |=> !trig_seen) else $error("trigger pulse too long");
    trig_active_a: assert property (trig_seen |-> chan_active) else $error("trigger served early");
    id_match_a: assert property (trig_seen |-> ##6 (trig_match == (trig_id == 8'h04))) else $error("id match");
    in_start_a: assert property (trig_seen |-> ##5 !in_valid ##1 in_valid) else $error("stream late");
    in_end_a: assert property (in_last |-> in_valid ##1 !in_valid) else $error("stream runs on");
    // counter moves by one only, and only once the buffer is complete
    cnt_step_a: assert property ($changed(out_count) |-> out_count == $past(out_count) + 8'h01)
        else $error("counter step");
    cnt_late_a: assert property ($changed(out_count) |-> !res_ready) else $error("count during write");
    pub_due_a: assert property ($fell(res_ready) |-> ##[1:3] $changed(out_count)) else $error("no publish");
    act_hold_a: assert property (chan_active |=> chan_active) else $error("active flag dropped");
    ptr_spill_a: assert property (setup_valid && setup_ready && !setup_is_ofs |=> !setup_ready)
        else $error("pointer not spilled");
    cover property (trig_seen);
    cover property (in_last);
    cover property ($changed(out_count));
endmodule // bcm_mailbox_checker
bind bcm_mailbox bcm_mailbox_checker u_chk (.clk(clk), .sys_rst(sys_rst), .setup_valid(setup_valid),
    .setup_is_ofs(setup_is_ofs), .setup_ready(setup_ready), .chan_active(chan_active), .trig_seen(trig_seen),
    .trig_id(trig_id), .trig_match(trig_match), .in_valid(in_valid), .in_last(in_last),
    .res_ready(res_ready), .out_count(out_count));

// >>> testbench/bcm_ecu_model.sv
// control-unit model: bus master on the shared window
// assumes its tasks are entered just after a rising edge
`timescale 1ns/100ps
module bcm_ecu_model (input wire clk, output reg [8:0] ecu_addr, output reg [7:0] ecu_wdata,
    output reg ecu_wr, output reg ecu_rd);
    initial {ecu_addr, ecu_wdata, ecu_wr, ecu_rd} = 19'h00000;
    // one strobe then an idle edge, so no strobe is assigned twice in a step
    task acc(input w, input [8:0] a, input [7:0] d);
        begin
            ecu_addr <= a; ecu_wdata <= d; ecu_wr <= w; ecu_rd <= !w;
            @(posedge clk);
            ecu_wr <= 1'b0; ecu_rd <= 1'b0; ecu_wdata <= ~d;
            @(posedge clk);
        end
    endtask
    // input bytes first, then the channel id, then any value to the trigger
    task cycle(input [7:0] b0, input [7:0] b1, input [7:0] junk);
        begin
            acc(1'b1, 9'h080, b0);
            acc(1'b1, 9'h081, b1);
            acc(1'b1, 9'h0F0, 8'h04);
            acc(1'b1, 9'h0F1, junk);
        end
    endtask
endmodule // bcm_ecu_model

// >>> testbench/tb.sv
// bench: byte-wise setup, two trigger rounds, both output buffers read back
// assumes default parameters and the layout constants of the header
`timescale 1ns/100ps
`include "bcm_regs.vh"
module tb;
    reg         clk = 1'b0, sys_rst = 1'b1, st = 1'b0, sv = 1'b0, so = 1'b0, sl = 1'b0, rv = 1'b0, rd_d = 1'b0;
    reg         fm = 1'b0, mf = 1'b0;
    reg  [31:0] sd = 32'h0, p0, p1, o0;
    reg  [7:0]  rdat = 8'h00, oc_d = 8'h00, c8 = 8'h00, rb [0:199];
    wire [8:0]  a;
    wire [7:0]  wd, rdata, idat, oc;
    wire        wr, rd, srdy, act, iv, rrdy;
    integer     num_errors = 0, compares = 0, k, r;
    reg  [7:0]  qr [$], qi [$], qc [$];
    always #5 clk = ~clk;
    bcm_ecu_model u_ecu (.clk(clk), .ecu_addr(a), .ecu_wdata(wd), .ecu_wr(wr), .ecu_rd(rd));
    bcm_mailbox uut (.clk(clk), .sys_rst(sys_rst), .ecu_addr(a), .ecu_wdata(wd), .ecu_wr(wr), .ecu_rd(rd),
        .ecu_rdata(rdata), .setup_start(st), .setup_format(fm), .setup_msb_first(mf),
        .setup_cnt8(c8), .setup_cnt4(c8), .setup_cnt2(c8), .setup_cnt1(c8), .setup_valid(sv),
        .setup_is_ofs(so), .setup_last(sl), .setup_data(sd), .setup_ready(srdy), .chan_active(act),
        .trig_seen(), .trig_id(), .trig_match(), .in_valid(iv), .in_last(), .in_data(idat),
        .res_valid(rv), .res_data(rdat), .res_ready(rrdy), .out_count(oc));
    task chk(input [8*9:1] n, input [7:0] e, input [7:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin num_errors = num_errors + 1; $display("wrong value %0s exp %h got %h", n, e, g); end
        end
    endtask
    task conclude;
        begin
            $display("errors %0d compares %0d", num_errors, compares);
            if (num_errors == 0 && compares > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task rdx(input [8:0] ad, input [7:0] e); begin qr.push_back(e); u_ecu.acc(1'b0, ad, 8'h00); end endtask
    // offer one setup item and hold it until the engine takes it
    task item(input o, input l, input [31:0] d);
        begin sv <= 1'b1; so <= o; sl <= l; sd <= d; @(posedge clk); while (srdy !== 1'b1) @(posedge clk); end
    endtask
    // watcher: each result takes the oldest note of its kind
    always @(posedge clk) begin
        rd_d <= rd; oc_d <= oc;
        if (rd_d) chk("rdata", qr.pop_front(), rdata);
        if (iv) chk("in_data", qi.pop_front(), idat);
        if (oc !== oc_d && !sys_rst) chk("out_count", qc.pop_front(), oc);
    end
    // hang guard, far beyond the expected run of some seven hundred cycles
    initial begin #100000; num_errors = num_errors + 1; conclude; end
    initial begin
        void'($urandom(32'h029A05F9));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0; c8 <= $urandom;
        @(posedge clk); st <= 1'b1;
        @(posedge clk); st <= 1'b0;
        p0 = $urandom & 32'h0000FFFF; p1 = $urandom & 32'h0000FFFF; o0 = $urandom & 32'h000000FF;
        item(1'b1, 1'b0, o0);
        item(1'b0, 1'b0, p0);
        item(1'b0, 1'b1, p1);
        sv <= 1'b0;
        for (k = 0; k < 50 && act !== 1'b1; k = k + 1) @(posedge clk);
        rdx(9'h001, 8'h01);
        rdx(9'h000, 8'h02);
        rdx(9'h002, p0[7:0]); rdx(9'h003, p0[15:8]); rdx(9'h005, p1[15:8]);
        rdx(9'h100, o0[7:0]);
        for (r = 1; r < 3; r = r + 1) begin
            k = $urandom; qi.push_back(k[7:0]); qi.push_back(k[15:8]); qc.push_back(r[7:0]);
            u_ecu.cycle(k[7:0], k[15:8], k[23:16]);
            for (k = 0; k < 100; k = k + 1) begin
                rb[r*100+k-100] = $urandom; rv <= 1'b1; rdat <= rb[r*100+k-100];
                @(posedge clk); while (rrdy !== 1'b1) @(posedge clk);
            end
            rv <= 1'b0;
            repeat (8) @(posedge clk);
        end
        for (k = 0; k < 100; k = k + 1) begin
            rdx(`BCM_OUT1_BASE + k, rb[k]);
            rdx(`BCM_OUT1_BASE + `BCM_OUT_SIZE + k, rb[k+100]);
        end
        rdx(`BCM_CNT_LOC, 8'h02);
        // mid-run reset, then a signal-wise list, msb first, with random counts
        sys_rst <= 1'b1; fm <= `BCM_FMT_SIGNALWISE; mf <= 1'b1; c8 <= $urandom;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk); st <= 1'b1;
        @(posedge clk); st <= 1'b0; p1 = $urandom;
        item(1'b0, 1'b1, p1);
        sv <= 1'b0;
        for (k = 0; k < 50 && act !== 1'b1; k = k + 1) @(posedge clk);
        rdx(9'h000, 8'h01);
        for (k = 0; k < 4; k = k + 1) begin
            rdx(9'h004 + k, c8);
            rdx(9'h00B - k, p1[8*k +: 8]);
        end
        conclude;
    end
endmodule // tb
